/* File: inc/motor_status_pkg.sv */
// Constants and carrier types for the motor status output logic.
// Overview of operation
// - Mode 0: speed attained while measured speed is within tolerance of command speed.
// - Mode 1: speed attained when profiled command speed equals target speed.
// - Mode 2: speed attained while measured speed is within tolerance of target speed.
// - Mode codes: 0 measured, 1 command match, 2 combined; default 0.
// - Pulse-input operation always uses mode 0.
// - Tolerance band is 1 to 200 r/min, default 30.
// - Current clamp request limits current and flags it at or above limit.
// - Current limit is 0 to 1000 tenths of a percent of base, default 500.
// - Speed clamp request limits speed and flags it at or above limit.
// - Speed limit type: 0 ratio, 1 absolute value; default 0.
// - Ratio limit is 1 to 100 percent of data speed, default 50.
// - Value limit is 1 to 4000000 Hz, default 1000.
// - Homing done rises on homing completion or position preset.
// - Data number toggle flips on data-driven start or number change mid-operation.
// - Active data number is shown in binary, bit 0 least significant.
// - Operations without data keep the previous active data number.
// - Each done flag clears on start, sets when its data number completes.
// - Each done flag selects data number 0 to 255; flag n defaults to n.
// - Hold request in stored-data operation raises pause active.
package motor_status_pkg;

  localparam logic [1:0] VA_MODE_MEASURED = 2'h0;
  localparam logic [1:0] VA_MODE_COMMAND = 2'h1;
  localparam logic [1:0] VA_MODE_COMBINED = 2'h2;
  localparam logic [7:0] VA_TOL_MIN = 8'h01;
  localparam logic [7:0] VA_TOL_MAX = 8'hC8;
  localparam logic [7:0] VA_TOL_DEFAULT = 8'h1E;
  localparam logic [9:0] CUR_LIMIT_MAX = 10'h3E8;
  localparam logic [9:0] CUR_LIMIT_DEFAULT = 10'h1F4;
  localparam logic SPD_TYPE_RATIO = 1'b0;
  localparam logic SPD_TYPE_VALUE = 1'b1;
  localparam logic [6:0] SPD_RATIO_MIN = 7'h01;
  localparam logic [6:0] SPD_RATIO_MAX = 7'h64;
  localparam logic [6:0] SPD_RATIO_DEFAULT = 7'h32;
  localparam logic [28:0] SPD_RATIO_FULL = 29'h0000064;
  localparam logic [21:0] SPD_VALUE_MIN = 22'h000001;
  localparam logic [21:0] SPD_VALUE_MAX = 22'h3D0900;
  localparam logic [21:0] SPD_VALUE_DEFAULT = 22'h0003E8;
  localparam int DONE_COUNT = 8;

  typedef logic [7:0] data_num_type;

  // Configuration as software would hold it; defaults above are its reset values.
  typedef struct packed {
    logic [1:0] vaMode;
    logic [7:0] vaTolerance;
    logic [9:0] currentLimit;
    logic speedLimitType;
    logic [6:0] speedLimitRatio;
    logic [21:0] speedLimitValue;
    data_num_type [DONE_COUNT-1:0] doneSelect;
  } cfg_type;

  // Measured and demanded motion quantities.
  typedef struct packed {
    logic [15:0] measuredRpm;
    logic [15:0] commandRpm;
    logic [15:0] targetRpm;
    logic [9:0] operatingCurrent;
    logic [21:0] operatingSpeedHz;
    logic [21:0] dataSpeedHz;
  } motion_type;

  // Sequencer events and requests.
  typedef struct packed {
    logic pulseInput;
    logic dataDriven;
    logic storedData;
    logic opStart;
    logic opComplete;
    data_num_type dataNumber;
    logic homingComplete;
    logic presetDone;
    logic pauseRequest;
    logic currentClampRequest;
    logic speedClampRequest;
  } op_type;

  typedef struct packed {
    logic speedAttained;
    logic currentClampedFlag;
    logic speedClampedFlag;
    logic homingDone;
    logic dataNumberToggle;
    data_num_type activeDataNumber;
    logic [DONE_COUNT-1:0] dataDoneFlags;
    logic pauseActive;
    logic opRunning;
    logic [9:0] clampedCurrent;
    logic [21:0] clampedSpeedHz;
  } state_type;

endpackage : motor_status_pkg

/* File: rtl/motor_status_outputs.sv */
// Status output logic of a stepping motor driver.
`timescale 1ns/1ps
`default_nettype none

module motor_status_outputs
  import motor_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Configuration, motion and sequencer inputs
  input wire cfg_type cfg,
  input wire motion_type motion,
  input wire op_type op,
  // Status outputs
  output logic speedAttained,
  output logic currentClampedFlag,
  output logic speedClampedFlag,
  output logic homingDone,
  output logic dataNumberToggle,
  output logic [7:0] activeDataNumber,
  output logic [DONE_COUNT-1:0] dataDoneFlags,
  output logic pauseActive,
  // Clamped drive values handed to the motion core
  output logic [9:0] clampedCurrent,
  output logic [21:0] clampedSpeedHz
);

  state_type state_r;
  state_type state_nxt;

  logic [7:0] tolerance;
  logic [9:0] curLimit;
  logic [6:0] ratio;
  logic [21:0] valueLimit;
  logic [21:0] spdLimit;
  logic [28:0] ratioProduct;
  logic [1:0] effMode;
  logic [15:0] diffCommand;
  logic [15:0] diffTarget;
  logic nearCommand;
  logic nearTarget;
  logic numberChanged;
  logic [DONE_COUNT-1:0] doneHit;

  // Out-of-range settings are saturated so a bad write cannot disable a flag.
  always_comb
  begin
    tolerance = cfg.vaTolerance;
    if (tolerance < VA_TOL_MIN)
      tolerance = VA_TOL_MIN;
    else if (tolerance > VA_TOL_MAX)
      tolerance = VA_TOL_MAX;
    curLimit = cfg.currentLimit;
    if (curLimit > CUR_LIMIT_MAX)
      curLimit = CUR_LIMIT_MAX;
    ratio = cfg.speedLimitRatio;
    if (ratio < SPD_RATIO_MIN)
      ratio = SPD_RATIO_MIN;
    else if (ratio > SPD_RATIO_MAX)
      ratio = SPD_RATIO_MAX;
    valueLimit = cfg.speedLimitValue;
    if (valueLimit < SPD_VALUE_MIN)
      valueLimit = SPD_VALUE_MIN;
    else if (valueLimit > SPD_VALUE_MAX)
      valueLimit = SPD_VALUE_MAX;
  end

  // The divide by a constant costs area but keeps the ratio exact to the hertz.
  assign ratioProduct = 29'(motion.dataSpeedHz) * 29'(ratio);
  assign spdLimit = (cfg.speedLimitType == SPD_TYPE_RATIO) ?
    22'(ratioProduct / SPD_RATIO_FULL) : valueLimit;

  // Pulse-input operation has no internal profile, so only mode 0 applies.
  assign effMode = (op.pulseInput || cfg.vaMode > VA_MODE_COMBINED) ?
    VA_MODE_MEASURED : cfg.vaMode;

  assign diffCommand = (motion.measuredRpm >= motion.commandRpm) ?
    motion.measuredRpm - motion.commandRpm : motion.commandRpm - motion.measuredRpm;
  assign diffTarget = (motion.measuredRpm >= motion.targetRpm) ?
    motion.measuredRpm - motion.targetRpm : motion.targetRpm - motion.measuredRpm;
  assign nearCommand = diffCommand <= 16'(tolerance);
  assign nearTarget = diffTarget <= 16'(tolerance);

  assign numberChanged = state_r.opRunning && op.dataNumber != state_r.activeDataNumber;

  generate
    for (genvar i = 0; i < DONE_COUNT; i++)
    begin : g_done
      assign doneHit[i] = op.opComplete && op.dataDriven &&
        op.dataNumber == cfg.doneSelect[i];
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    case (effMode)
      VA_MODE_MEASURED: state_nxt.speedAttained = nearCommand;
      VA_MODE_COMMAND: state_nxt.speedAttained =
        motion.commandRpm == motion.targetRpm;
      VA_MODE_COMBINED: state_nxt.speedAttained = nearTarget;
      default: state_nxt.speedAttained = 1'b0;
    endcase

    state_nxt.clampedCurrent = motion.operatingCurrent;
    state_nxt.currentClampedFlag = 1'b0;
    if (op.currentClampRequest && motion.operatingCurrent >= curLimit)
    begin
      state_nxt.clampedCurrent = curLimit;
      state_nxt.currentClampedFlag = 1'b1;
    end

    state_nxt.clampedSpeedHz = motion.operatingSpeedHz;
    state_nxt.speedClampedFlag = 1'b0;
    if (op.speedClampRequest && motion.operatingSpeedHz >= spdLimit)
    begin
      state_nxt.clampedSpeedHz = spdLimit;
      state_nxt.speedClampedFlag = 1'b1;
    end

    // A new operation clears the old homing flag; a completion in the same cycle wins.
    if (op.opStart)
      state_nxt.homingDone = 1'b0;
    if (op.homingComplete || op.presetDone)
      state_nxt.homingDone = 1'b1;

    if (op.dataDriven)
    begin
      if (op.opStart || numberChanged)
        state_nxt.dataNumberToggle = ~state_r.dataNumberToggle;
      if (op.opStart || state_r.opRunning)
        state_nxt.activeDataNumber = op.dataNumber;
    end
    // Without operation data the number simply stays as it was.

    if (op.opStart)
      state_nxt.opRunning = op.dataDriven;
    if (op.opComplete)
      state_nxt.opRunning = 1'b0;

    if (op.opStart)
      state_nxt.dataDoneFlags = '0;
    state_nxt.dataDoneFlags = state_nxt.dataDoneFlags | doneHit;

    state_nxt.pauseActive = op.pauseRequest && op.storedData;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign speedAttained = state_r.speedAttained;
  assign currentClampedFlag = state_r.currentClampedFlag;
  assign speedClampedFlag = state_r.speedClampedFlag;
  assign homingDone = state_r.homingDone;
  assign dataNumberToggle = state_r.dataNumberToggle;
  assign activeDataNumber = state_r.activeDataNumber;
  assign dataDoneFlags = state_r.dataDoneFlags;
  assign pauseActive = state_r.pauseActive;
  assign clampedCurrent = state_r.clampedCurrent;
  assign clampedSpeedHz = state_r.clampedSpeedHz;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  va_measured_a: assert property (effMode == VA_MODE_MEASURED |=>
    speedAttained == $past(nearCommand))
    else $error("speed attained wrong in measured mode");

  va_command_a: assert property (effMode == VA_MODE_COMMAND &&
    motion.commandRpm != motion.targetRpm |=> !speedAttained)
    else $error("speed attained without command match");

  va_combined_a: assert property (effMode == VA_MODE_COMBINED && !nearTarget
    |=> !speedAttained)
    else $error("speed attained outside target band");

  va_pulse_a: assert property (op.pulseInput && !nearCommand |=> !speedAttained)
    else $error("pulse input did not use measured mode");

  current_clamp_a: assert property (op.currentClampRequest &&
    motion.operatingCurrent >= curLimit |=> currentClampedFlag &&
    clampedCurrent == $past(curLimit))
    else $error("current not clamped at limit");

  current_free_a: assert property (!op.currentClampRequest |=>
    !currentClampedFlag && clampedCurrent == $past(motion.operatingCurrent))
    else $error("current clamped without request");

  speed_clamp_a: assert property (op.speedClampRequest &&
    motion.operatingSpeedHz >= spdLimit |=> speedClampedFlag &&
    clampedSpeedHz == $past(spdLimit))
    else $error("speed not clamped at limit");

  home_done_a: assert property (op.homingComplete || op.presetDone |=> homingDone)
    else $error("homing done not raised");

  toggle_start_a: assert property (op.opStart && op.dataDriven |=>
    dataNumberToggle != $past(dataNumberToggle))
    else $error("data number toggle did not flip on start");

  number_show_a: assert property (op.opStart && op.dataDriven |=>
    activeDataNumber == $past(op.dataNumber))
    else $error("active data number not shown");

  number_hold_a: assert property (!op.dataDriven |=> $stable(activeDataNumber))
    else $error("active data number changed without data");

  done_clear_a: assert property (op.opStart && !op.opComplete |=>
    dataDoneFlags == '0)
    else $error("done flags not cleared on start");

  done_set_a: assert property (op.opComplete && op.dataDriven &&
    op.dataNumber == cfg.doneSelect[0] |=> dataDoneFlags[0])
    else $error("done flag 0 not set");

  pause_a: assert property (op.pauseRequest && op.storedData |=> pauseActive)
    else $error("pause active not raised");

  reset_clear_a: assert property (@(posedge clk_sys) disable iff (1'b0)
    !rstn |=> !speedAttained && !homingDone && dataDoneFlags == '0)
    else $error("outputs not cleared by reset");

  cover_limit_c: cover property (speedClampedFlag && currentClampedFlag);
  cover_change_c: cover property (op.opStart ##[1:20] numberChanged && op.dataDriven);
  cover_home_c: cover property (homingDone ##1 op.opStart ##1 !homingDone);
  cover_pause_c: cover property (pauseActive ##[1:10] !pauseActive);

endmodule : motor_status_outputs

`default_nettype wire

/* File: verif/host_monitor.sv */
// Host controller model that watches the data number toggle output.
`timescale 1ns/1ps
`default_nettype none

module host_monitor
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched output
  input wire logic dataNumberToggle,
  output int flips
);
  logic lastToggle_r;

  // The host only sees edges, so it counts flips rather than levels.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      lastToggle_r <= 1'b0;
      flips <= 0;
    end
    else
    begin
      lastToggle_r <= dataNumberToggle;
      if (dataNumberToggle !== lastToggle_r)
        flips <= flips + 1;
    end
  end
endmodule : host_monitor

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking testbench for the motor status output logic.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import motor_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  cfg_type cfg;
  motion_type motion;
  op_type op;
  logic speedAttained, currentClampedFlag, speedClampedFlag, homingDone, dataNumberToggle;
  logic pauseActive, expTog, curHit, spdHit;
  logic [7:0] activeDataNumber;
  logic [DONE_COUNT-1:0] dataDoneFlags;
  logic [9:0] clampedCurrent, cl;
  logic [21:0] clampedSpeedHz;
  longint sl;
  int n_fail = 0, samples_checked = 0, cycles = 0, flips, i, d;

  motor_status_outputs i_motor_status_outputs (.clk_sys(clk_sys), .rstn(rstn), .cfg(cfg),
    .motion(motion), .op(op), .speedAttained(speedAttained),
    .currentClampedFlag(currentClampedFlag), .speedClampedFlag(speedClampedFlag),
    .homingDone(homingDone), .dataNumberToggle(dataNumberToggle),
    .activeDataNumber(activeDataNumber), .dataDoneFlags(dataDoneFlags),
    .pauseActive(pauseActive), .clampedCurrent(clampedCurrent),
    .clampedSpeedHz(clampedSpeedHz));
  host_monitor i_host_monitor (.clk_sys(clk_sys), .rstn(rstn),
    .dataNumberToggle(dataNumberToggle), .flips(flips));

  always #4 clk_sys = ~clk_sys;

  task automatic results();
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // A hang costs one mismatch and ends the run.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      results();
    end
  end

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  function automatic logic vaExp(cfg_type c, motion_type m, op_type o);
    logic [1:0] md;
    md = (o.pulseInput || c.vaMode == 2'h3) ? VA_MODE_MEASURED : c.vaMode;
    if (md == VA_MODE_COMMAND)
      return m.commandRpm == m.targetRpm;
    if (md == VA_MODE_COMBINED)
      return (m.measuredRpm > m.targetRpm ? m.measuredRpm - m.targetRpm
        : m.targetRpm - m.measuredRpm) <= c.vaTolerance;
    return (m.measuredRpm > m.commandRpm ? m.measuredRpm - m.commandRpm
      : m.commandRpm - m.measuredRpm) <= c.vaTolerance;
  endfunction : vaExp

  initial
  begin
    cfg = '0;
    motion = '0;
    op = '0;
    cfg.vaTolerance = VA_TOL_DEFAULT;
    cfg.currentLimit = CUR_LIMIT_DEFAULT;
    cfg.speedLimitRatio = SPD_RATIO_DEFAULT;
    cfg.speedLimitValue = SPD_VALUE_DEFAULT;
    for (i = 0; i < DONE_COUNT; i++)
      cfg.doneSelect[i] = 8'(i);
    void'($urandom(59));
    repeat (20) @(posedge clk_sys);
    chk("outputs in reset", 32'h0, {speedAttained, homingDone, activeDataNumber, dataDoneFlags});
    #1 rstn = 1'b1;
    for (i = 0; i < 300; i++)
    begin
      cfg.vaMode = 2'(i % 4);
      // Pulse input lands on modes 1, 2 and 3, where it must force mode 0.
      op.pulseInput = (i % 8 >= 5);
      cfg.vaTolerance = 8'($urandom_range(1, 200));
      motion.commandRpm = 16'($urandom_range(300, 60000));
      motion.targetRpm = (i % 3 == 0) ? motion.commandRpm : 16'($urandom_range(300, 60000));
      d = $urandom_range(0, 2 * cfg.vaTolerance + 4);
      motion.measuredRpm = 16'(((i % 4 == 2) ? motion.targetRpm : motion.commandRpm)
        + d - cfg.vaTolerance - 2);
      cfg.currentLimit = 10'($urandom_range(0, 1000));
      motion.operatingCurrent = 10'($urandom_range(0, 1023));
      if (i % 2 == 0)
        motion.operatingCurrent = cfg.currentLimit;
      op.currentClampRequest = 1'($urandom);
      cfg.speedLimitType = 1'($urandom);
      cfg.speedLimitRatio = 7'($urandom_range(1, 100));
      cfg.speedLimitValue = 22'($urandom_range(1, 4000000));
      motion.dataSpeedHz = 22'($urandom_range(0, 4000000));
      sl = cfg.speedLimitType ? cfg.speedLimitValue
        : longint'(motion.dataSpeedHz) * cfg.speedLimitRatio / 100;
      motion.operatingSpeedHz = 22'(sl + $urandom_range(0, 8) - 4);
      op.speedClampRequest = 1'($urandom);
      tick();
      chk("speedAttained", vaExp(cfg, motion, op), speedAttained);
      curHit = op.currentClampRequest && motion.operatingCurrent >= cfg.currentLimit;
      spdHit = op.speedClampRequest && motion.operatingSpeedHz >= sl;
      cl = curHit ? cfg.currentLimit : motion.operatingCurrent;
      chk("currentClampedFlag", curHit, currentClampedFlag);
      chk("clampedCurrent", cl, clampedCurrent);
      chk("speedClampedFlag", spdHit, speedClampedFlag);
      chk("clampedSpeedHz", spdHit ? 22'(sl) : motion.operatingSpeedHz, clampedSpeedHz);
    end
    op = '0;
    // A limit written above its range must act as the top of the range.
    op.currentClampRequest = 1'b1;
    cfg.currentLimit = 10'h3FF;
    motion.operatingCurrent = 10'h3F2;
    tick();
    chk("clampedCurrent saturated", CUR_LIMIT_MAX, clampedCurrent);
    op.currentClampRequest = 1'b0;
    expTog = dataNumberToggle;
    cfg.doneSelect[2] = 8'h05;
    op.homingComplete = 1'b1;
    tick();
    op.homingComplete = 1'b0;
    chk("homingDone", 32'h1, homingDone);
    op.dataDriven = 1'b1;
    op.opStart = 1'b1;
    op.dataNumber = 8'h03;
    tick();
    op.opStart = 1'b0;
    expTog = ~expTog;
    chk("toggle on start", expTog, dataNumberToggle);
    chk("activeDataNumber", 32'h3, activeDataNumber);
    chk("dataDoneFlags start", 32'h0, dataDoneFlags);
    op.dataNumber = 8'h05;
    tick();
    expTog = ~expTog;
    chk("toggle on change", expTog, dataNumberToggle);
    chk("activeDataNumber", 32'h5, activeDataNumber);
    op.opComplete = 1'b1;
    tick();
    chk("dataDoneFlags done", 32'h24, dataDoneFlags);
    op.opStart = 1'b1;
    op.dataNumber = 8'h00;
    tick();
    expTog = ~expTog;
    chk("dataDoneFlags back to back", 32'h1, dataDoneFlags);
    chk("toggle back to back", expTog, dataNumberToggle);
    op.opComplete = 1'b0;
    op.dataDriven = 1'b0;
    op.dataNumber = 8'h09;
    tick();
    op.opStart = 1'b0;
    op.presetDone = 1'b1;
    tick();
    op.presetDone = 1'b0;
    chk("activeDataNumber held", 32'h0, activeDataNumber);
    chk("toggle held", expTog, dataNumberToggle);
    chk("homingDone preset", 32'h1, homingDone);
    chk("host flips", 32'h3, flips);
    op.storedData = 1'b1;
    op.pauseRequest = 1'b1;
    tick();
    chk("pauseActive", 32'h1, pauseActive);
    op.storedData = 1'b0;
    tick();
    chk("pauseActive idle", 32'h0, pauseActive);
    results();
  end
endmodule : testbench

`default_nettype wire
